// ===== verilog/daa_control_status_registers.sv
// Register bank of the data access arrangement, host and line-side maps.
// Assumes an Avalon-MM master on MCLK and status inputs synchronous to it.
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ns
module daa_control_status_registers #(
  parameter int LS_GAP = daa_regs_pkg::LS_GAP_CYCLES,
  parameter logic [3:0] HOST_REV = daa_regs_pkg::HOST_REV_DEFAULT,
  parameter logic [3:0] LINE_REV = daa_regs_pkg::LINE_REV_DEFAULT
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // Avalon-MM slave
  input wire daa_regs_pkg::avs_req_t AVS_REQ,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Device status
  input wire daa_regs_pkg::line_status_t STATUS,
  // Register contents and decoded controls
  output logic [31:0][7:0] CTRL_REGS,
  output daa_regs_pkg::line_ctrl_t LINE_CTRL,
  // Interrupt
  output logic IRQ
);
  import daa_regs_pkg::*;

  bank_state_t s_q;
  bank_state_t s_d;
  logic [5:0] idx;
  logic aligned;
  logic mapped;
  logic is_bank;
  logic line_side;
  logic req;
  logic gap_stall;
  logic [7:0] wr_byte;
  logic [7:0] ro_val;
  logic [7:0] rd_byte;
  logic [7:0] ev_raw;
  logic [7:0] ev_en;
  logic [7:0] ev_fire;
  logic [7:0] w1c;
  logic [15:0] gap_load;

  // Address decode: word index, lane 0 only
  assign idx = AVS_REQ.address[7:2];
  assign aligned = AVS_REQ.address[1:0] == 2'h0;
  assign is_bank = (idx >= IDX_SERIAL_CFG && idx <= IDX_CALL_MON) ||
                   (idx >= IDX_LINE_HOOK && idx <= IDX_POLARITY);
  assign mapped = aligned && (is_bank || idx == IDX_IRQ_STATUS || idx == IDX_IRQ_MASK);
  assign line_side = idx >= IDX_LS_FIRST && idx <= IDX_POLARITY;
  assign req = AVS_REQ.read || AVS_REQ.write;
  assign wr_byte = AVS_REQ.writedata[7:0];
  assign gap_load = 16'(LS_GAP - 1);

  // Line-side writes wait until the spacing from the last one has run out
  assign gap_stall = AVS_REQ.write && mapped && line_side && s_q.gap_cnt != 16'h0000;

  // Read-only values driven by the device, per index
  always_comb
  begin
    unique case (idx)
      IDX_GPIO_STATUS:
        ro_val = {4'h0, STATUS.ring_monitor, STATUS.line_detect,
                  STATUS.barrier_sync, STATUS.ring_detect};
      IDX_GPIO_DIR_REV: ro_val = {4'h0, HOST_REV};
      IDX_PLL_LOCK: ro_val = {STATUS.pll_locked, STATUS.line_side_sleep_host, 6'h00};
      IDX_IDLE_POLL: ro_val = {1'b0, STATUS.poll_match, 6'h00};
      IDX_RING: ro_val = STATUS.ring_sample;
      IDX_LINE_V: ro_val = {STATUS.line_voltage[7:1], 1'b0};
      IDX_LOOP_I: ro_val = {STATUS.loop_current[7:1], 1'b0};
      IDX_LS_REV: ro_val = {LINE_REV, 4'h0};
      IDX_FAULT_STAT: ro_val = {STATUS.line_fault, 3'h0};
      IDX_POLARITY: ro_val = STATUS.polarity_value;
      default: ro_val = 8'h00;
    endcase
  end

  // Read value: stored bits, device bits; write-only bits show zero
  always_comb
  begin
    rd_byte = 8'h00;
    if (mapped)
    begin
      if (idx == IDX_IRQ_STATUS)
        rd_byte = s_q.irq_status;
      else if (idx == IDX_IRQ_MASK)
        rd_byte = s_q.irq_mask;
      else
        rd_byte = (s_q.regs[idx[4:0]] & ~wo_mask(idx) & ~ro_mask(idx)) |
                  (ro_val & ro_mask(idx));
    end
  end

  // Event sources: rising edges of line status, falling lock, polarity flip
  assign ev_raw[EV_RING] = STATUS.ring_detect;
  assign ev_raw[EV_DET] = STATUS.line_detect;
  assign ev_raw[EV_SYNC] = STATUS.barrier_sync;
  assign ev_raw[EV_LOCK_LOSS] = ~STATUS.pll_locked;
  assign ev_raw[EV_OVER_CURRENT] = STATUS.line_fault[1];
  assign ev_raw[EV_OVER_VOLTAGE] = STATUS.line_fault[2];
  assign ev_raw[EV_UNDER_VOLTAGE] = STATUS.line_fault[3];
  assign ev_raw[EV_POLARITY] = STATUS.polarity_value[7];

  // Enables taken from the stored control bits, write-only ones included; lock loss is always enabled
  assign ev_en[EV_RING] = s_q.regs[IDX_EVENT_ENABLE[4:0]][RING_STATUS_EN_BIT];
  assign ev_en[EV_DET] = s_q.regs[IDX_EVENT_ENABLE[4:0]][DET_EN_BIT];
  assign ev_en[EV_SYNC] = s_q.regs[IDX_EVENT_ENABLE[4:0]][SYNC_EN_BIT];
  assign ev_en[EV_LOCK_LOSS] = 1'b1;
  assign ev_en[EV_OVER_CURRENT] = s_q.regs[IDX_FAULT_EN[4:0]][OC_EN_BIT];
  assign ev_en[EV_OVER_VOLTAGE] = s_q.regs[IDX_FAULT_EN[4:0]][OV_EN_BIT];
  assign ev_en[EV_UNDER_VOLTAGE] = s_q.regs[IDX_FAULT_EN[4:0]][UV_EN_BIT];
  assign ev_en[EV_POLARITY] = s_q.regs[IDX_EVENT_ENABLE[4:0]][POL_EN_BIT];

  // Edge detection per event; polarity fires on either edge
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_event
      if (g == EV_POLARITY)
      begin : g_both
        assign ev_fire[g] = ev_en[g] && (ev_raw[g] != s_q.ev_prev[g]);
      end
      else
      begin : g_rise
        assign ev_fire[g] = ev_en[g] && ev_raw[g] && !s_q.ev_prev[g];
      end
    end
  endgenerate

  // Write-one-to-clear, only on the accepting edge
  assign w1c = (s_q.ack && AVS_REQ.write && mapped && idx == IDX_IRQ_STATUS &&
                AVS_REQ.byteenable[0]) ? wr_byte : 8'h00;

  // Reset image built as a constant, so the reset branch loads no logic
  function automatic bank_state_t reset_image();
    bank_state_t r;
    r = '0;
    for (int i = 0; i < 32; i++)
      r.regs[i] = reset_value(6'(i));
    return r;
  endfunction
  localparam bank_state_t S_RST = reset_image();

  // Next state
  always_comb
  begin
    s_d = s_q;
    s_d.ev_prev = ev_raw;
    // Set wins over a clear in the same cycle
    s_d.irq_status = (s_q.irq_status & ~w1c) | ev_fire;
    // Answer one cycle after the request appears, unless spacing holds it
    s_d.ack = req && !s_q.ack && !gap_stall;
    if (req && !s_q.ack && !gap_stall)
      s_d.readdata = {24'h000000, AVS_REQ.read ? rd_byte : 8'h00};
    if (s_q.gap_cnt != 16'h0000)
      s_d.gap_cnt = s_q.gap_cnt - 16'h0001;
    // Accepting edge: waitrequest is low in this cycle
    if (s_q.ack && AVS_REQ.write && mapped && AVS_REQ.byteenable[0])
    begin
      if (idx == IDX_IRQ_MASK)
        s_d.irq_mask = wr_byte;
      else if (is_bank)
        s_d.regs[idx[4:0]] = (s_q.regs[idx[4:0]] & ro_mask(idx)) |
                             (wr_byte & ~ro_mask(idx));
      if (line_side)
        s_d.gap_cnt = gap_load;
    end
  end

  // State register
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
      s_q <= S_RST;
    else
      s_q <= s_d;
  end

  // Bus answer
  assign AVS_WAITREQUEST = req && !s_q.ack;
  assign AVS_READDATA = s_q.readdata;

  // Controls straight from the stored bits; reads of the 0x12 and 0x15 ones show zero
  assign CTRL_REGS = s_q.regs;
  assign LINE_CTRL.dc_termination_enable = s_q.regs[IDX_LINE_HOOK[4:0]][DC_TERM_BIT];
  assign LINE_CTRL.ac_termination_enable = s_q.regs[IDX_LINE_HOOK[4:0]][AC_TERM_BIT];
  assign LINE_CTRL.low_side_feature_enable = s_q.regs[IDX_LINE_HOOK[4:0]][LOW_SIDE_BIT];
  assign LINE_CTRL.over_current_detect_enable = s_q.regs[IDX_FAULT_EN[4:0]][OC_EN_BIT];
  assign LINE_CTRL.over_voltage_detect_enable = s_q.regs[IDX_FAULT_EN[4:0]][OV_EN_BIT];
  assign LINE_CTRL.under_voltage_detect_enable = s_q.regs[IDX_FAULT_EN[4:0]][UV_EN_BIT];
  assign LINE_CTRL.ring_status_enable =
    s_q.regs[IDX_EVENT_ENABLE[4:0]][RING_STATUS_EN_BIT];
  assign LINE_CTRL.sample_rate_change_request =
    s_q.regs[IDX_PLL_LOCK[4:0]][RATE_CHANGE_BIT];

  // Level interrupt from flops only
  assign IRQ = |(s_q.irq_status & s_q.irq_mask);

endmodule // daa_control_status_registers

// ===== verilog/daa_regs_pkg.sv
// Constants, register layout and carrier types for the DAA register bank.
// Assumes a single 50 MHz clock and an Avalon-MM master with 32-bit data.
// Behaviour
// - Writes never alter read-only fields.
// - Fields act as read/write, write-only, read-only.
// - 0x12 bits 6,5,2 write-only, reset 0.
// - Over-current enable 0x15 bit 0, write-only.
// - Over-voltage enable 0x15 bit 1, write-only.
// - Under-voltage enable 0x15 bit 2, write-only.
// - Ring status enable 0x05 bit 0 resets 1.
// - Rate change request 0x0D bit 3 resets 0.
package daa_regs_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_SERIAL_CFG = 6'h01;
  localparam logic [5:0] IDX_HOST_MODE = 6'h02;
  localparam logic [5:0] IDX_GPIO_STATUS = 6'h03;
  localparam logic [5:0] IDX_GPIO_DIR_REV = 6'h04;
  localparam logic [5:0] IDX_EVENT_ENABLE = 6'h05;
  localparam logic [5:0] IDX_GPIO_POL = 6'h06;
  localparam logic [5:0] IDX_LOOPBACK = 6'h07;
  localparam logic [5:0] IDX_PRESCALE_SEQ = 6'h08;
  localparam logic [5:0] IDX_PRESCALE_DIV = 6'h09;
  localparam logic [5:0] IDX_PLL_GAIN = 6'h0A;
  localparam logic [5:0] IDX_FB_DIV = 6'h0B;
  localparam logic [5:0] IDX_FB_SEQ = 6'h0C;
  localparam logic [5:0] IDX_PLL_LOCK = 6'h0D;
  localparam logic [5:0] IDX_VCO_FORCE = 6'h0E;
  localparam logic [5:0] IDX_POWER = 6'h0F;
  localparam logic [5:0] IDX_CALL_MON = 6'h10;
  localparam logic [5:0] IDX_LINE_HOOK = 6'h12;
  localparam logic [5:0] IDX_DC_SHAPE = 6'h13;
  localparam logic [5:0] IDX_SIG_GAIN = 6'h14;
  localparam logic [5:0] IDX_FAULT_EN = 6'h15;
  localparam logic [5:0] IDX_CODEC = 6'h16;
  localparam logic [5:0] IDX_AC_IMP = 6'h17;
  localparam logic [5:0] IDX_LS_TEST = 6'h18;
  localparam logic [5:0] IDX_IDLE_POLL = 6'h19;
  localparam logic [5:0] IDX_RING = 6'h1A;
  localparam logic [5:0] IDX_LINE_V = 6'h1B;
  localparam logic [5:0] IDX_LOOP_I = 6'h1C;
  localparam logic [5:0] IDX_LS_REV = 6'h1D;
  localparam logic [5:0] IDX_FAULT_STAT = 6'h1E;
  localparam logic [5:0] IDX_POLARITY = 6'h1F;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h20;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h21;
  localparam logic [5:0] IDX_LS_FIRST = 6'h12;

  // Field positions
  localparam int RING_STATUS_EN_BIT = 0;
  localparam int SYNC_EN_BIT = 1;
  localparam int DET_EN_BIT = 2;
  localparam int POL_EN_BIT = 3;
  localparam int RATE_CHANGE_BIT = 3;
  localparam int DC_TERM_BIT = 6;
  localparam int AC_TERM_BIT = 5;
  localparam int LOW_SIDE_BIT = 2;
  localparam int OC_EN_BIT = 0;
  localparam int OV_EN_BIT = 1;
  localparam int UV_EN_BIT = 2;

  // Interrupt event positions
  localparam int EV_RING = 0;
  localparam int EV_DET = 1;
  localparam int EV_SYNC = 2;
  localparam int EV_LOCK_LOSS = 3;
  localparam int EV_OVER_CURRENT = 4;
  localparam int EV_OVER_VOLTAGE = 5;
  localparam int EV_UNDER_VOLTAGE = 6;
  localparam int EV_POLARITY = 7;

  // Line-side write spacing
  localparam int CLK_MHZ = 50;
  localparam int LS_GAP_US = 300;
  localparam int LS_GAP_CYCLES = LS_GAP_US * CLK_MHZ;
  localparam logic [3:0] HOST_REV_DEFAULT = 4'h3; // Arbitrary value
  localparam logic [3:0] LINE_REV_DEFAULT = 4'hC; // Arbitrary value

  // Reset value of the stored part of each register
  function automatic logic [7:0] reset_value(input logic [5:0] idx);
    unique case (idx)
      IDX_GPIO_STATUS: reset_value = 8'hF0;
      IDX_GPIO_DIR_REV: reset_value = 8'hF0;
      IDX_EVENT_ENABLE: reset_value = 8'h0B;
      IDX_PRESCALE_SEQ: reset_value = 8'hDA;
      IDX_PRESCALE_DIV: reset_value = 8'hEF;
      IDX_PLL_GAIN: reset_value = 8'h31;
      IDX_FB_DIV: reset_value = 8'h2A;
      IDX_FB_SEQ: reset_value = 8'h06;
      IDX_PLL_LOCK: reset_value = 8'h42;
      IDX_POWER: reset_value = 8'h2C;
      IDX_CODEC: reset_value = 8'h01;
      IDX_LS_TEST: reset_value = 8'h01;
      default: reset_value = 8'h00;
    endcase
  endfunction

  // Bits that software may write but never reads back
  function automatic logic [7:0] wo_mask(input logic [5:0] idx);
    unique case (idx)
      IDX_LINE_HOOK: wo_mask = 8'hFF;
      IDX_DC_SHAPE: wo_mask = 8'hFF;
      IDX_SIG_GAIN: wo_mask = 8'h60;
      IDX_FAULT_EN: wo_mask = 8'h47;
      default: wo_mask = 8'h00;
    endcase
  endfunction

  // Bits that the device itself drives
  function automatic logic [7:0] ro_mask(input logic [5:0] idx);
    unique case (idx)
      IDX_GPIO_STATUS: ro_mask = 8'h0F;
      IDX_GPIO_DIR_REV: ro_mask = 8'h0F;
      IDX_PLL_LOCK: ro_mask = 8'hC0;
      IDX_IDLE_POLL: ro_mask = 8'h40;
      IDX_RING, IDX_LINE_V, IDX_LOOP_I: ro_mask = 8'hFF;
      IDX_LS_REV, IDX_FAULT_STAT, IDX_POLARITY: ro_mask = 8'hFF;
      default: ro_mask = 8'h00;
    endcase
  endfunction

  // Avalon-MM request from the master
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avs_req_t;

  // Device-driven status that feeds read-only fields
  typedef struct packed {
    logic ring_monitor;
    logic line_detect;
    logic barrier_sync;
    logic ring_detect;
    logic pll_locked;
    logic line_side_sleep_host;
    logic poll_match;
    logic [7:0] ring_sample;
    logic [7:0] line_voltage;
    logic [7:0] loop_current;
    logic [4:0] line_fault;
    logic [7:0] polarity_value;
  } line_status_t;

  // Decoded line controls
  typedef struct packed {
    logic dc_termination_enable;
    logic ac_termination_enable;
    logic low_side_feature_enable;
    logic over_current_detect_enable;
    logic over_voltage_detect_enable;
    logic under_voltage_detect_enable;
    logic ring_status_enable;
    logic sample_rate_change_request;
  } line_ctrl_t;

  // Whole state of the register bank
  typedef struct packed {
    logic [31:0][7:0] regs;
    logic [7:0] irq_status;
    logic [7:0] irq_mask;
    logic [7:0] ev_prev;
    logic ack;
    logic [31:0] readdata;
    logic [15:0] gap_cnt;
  } bank_state_t;

endpackage

// ===== tb/daa_csr_sva.sv
// Port checker for the register bank: bus answer, read masks, line controls.
// Assumes a bind to the top module and the line-side gap set to at least eight cycles.
`timescale 1ns/1ns
module daa_csr_sva #(
  parameter int LS_GAP = 20
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // Bus
  input wire daa_regs_pkg::avs_req_t AVS_REQ,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  // Status, controls and interrupt
  input wire daa_regs_pkg::line_status_t STATUS,
  input wire daa_regs_pkg::line_ctrl_t LINE_CTRL,
  input wire logic IRQ
);
  import daa_regs_pkg::*;
  logic rd_acc;
  logic wr_acc;
  logic ls_wr;
  int since_ls;
  // Accepting edges; writes without lane 0 change nothing, so they are left out
  assign rd_acc = AVS_REQ.read && !AVS_WAITREQUEST;
  assign wr_acc = AVS_REQ.write && !AVS_WAITREQUEST && AVS_REQ.byteenable[0];
  assign ls_wr = wr_acc && AVS_REQ.address >= 8'h48 && AVS_REQ.address <= 8'h7C &&
                 AVS_REQ.address[1:0] == 2'h0;
  // Cycles since the last accepted line-side write, saturating at the gap
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
      since_ls <= LS_GAP;
    else if (ls_wr)
      since_ls <= 1;
    else if (since_ls < LS_GAP)
      since_ls <= since_ls + 1;
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  chk_read_answer: assert property (AVS_REQ.read && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("read not answered after one cycle");
  chk_read_upper: assert property (rd_acc |-> AVS_READDATA[31:8] == 24'h0)
    else $error("upper read lanes not zero");
  chk_wo_hook: assert property (rd_acc && AVS_REQ.address == 8'h48 |-> AVS_READDATA == 32'h0)
    else $error("hook register read back nonzero");
  chk_wo_fault: assert property (rd_acc && AVS_REQ.address == 8'h54 |-> AVS_READDATA[2:0] == 3'h0)
    else $error("fault enables read back nonzero");
  chk_hook_ctrl: assert property (wr_acc && AVS_REQ.address == 8'h48 |=>
    {LINE_CTRL.dc_termination_enable, LINE_CTRL.ac_termination_enable,
    LINE_CTRL.low_side_feature_enable} == {$past(AVS_REQ.writedata[6:5]), $past(AVS_REQ.writedata[2])})
    else $error("termination controls differ from write");
  chk_fault_ctrl: assert property (wr_acc && AVS_REQ.address == 8'h54 |=>
    {LINE_CTRL.under_voltage_detect_enable, LINE_CTRL.over_voltage_detect_enable,
    LINE_CTRL.over_current_detect_enable} == $past(AVS_REQ.writedata[2:0]))
    else $error("fault enables differ from write");
  chk_ro_live: assert property (AVS_REQ.read && AVS_WAITREQUEST && AVS_REQ.address == 8'h68 |=>
    AVS_READDATA[7:0] == $past(STATUS.ring_sample))
    else $error("ring sample read differs from input");
  chk_ls_spacing: assert property (ls_wr |=> !ls_wr [*8])
    else $error("line-side writes too close");
  chk_ls_gap_count: assert property (ls_wr |-> since_ls >= LS_GAP)
    else $error("line-side write inside the full spacing");
  chk_reset_ctrl: assert property ($rose(RST_N) |->
    LINE_CTRL.ring_status_enable && !LINE_CTRL.sample_rate_change_request)
    else $error("control reset values wrong");
  chk_mask_quiet: assert property (wr_acc && AVS_REQ.address == 8'h84 &&
    AVS_REQ.writedata[7:0] == 8'h00 |-> ##2 !IRQ)
    else $error("interrupt high with mask cleared");
endmodule // daa_csr_sva

// ===== tb/daa_host_model.sv
// Host side model: an Avalon-MM master issuing one byte transfer at a time.
// Assumes the slave answers on waitrequest; a wait past its bound sets timed_out.
`timescale 1ns/1ns
module daa_host_model (
  // Clock
  input wire logic MCLK,
  // Slave answer
  input wire logic [31:0] READDATA,
  input wire logic WAITREQUEST,
  // Request
  output daa_regs_pkg::avs_req_t REQ
);
  import daa_regs_pkg::*;
  logic timed_out;
  initial
  begin
    REQ = '0;
    timed_out = 1'b0;
  end
  // Raised after an edge, held until waitrequest is low at an edge
  task automatic xfer(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
    output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge MCLK);
    REQ <= '{read: !wr, write: wr, address: {idx, 2'b00}, writedata: {24'h0, wd},
      byteenable: 4'h1};
    // Line-side writes stall here until the device's spacing runs out
    @(negedge MCLK);
    while (WAITREQUEST !== 1'b0 && n < 2000)
    begin
      @(negedge MCLK);
      n++;
    end
    timed_out = (n >= 2000);
    rd = READDATA[7:0];
    @(posedge MCLK);
    REQ <= '0;
    @(negedge MCLK);
  endtask
endmodule // daa_host_model

// ===== tb/daa_control_status_registers_tb_top.sv
// Self-checking bench: reset map, random read back, write-only, read-only, interrupt.
// Assumes the host model as bus master and status inputs driven here.
`timescale 1ns/1ns
module daa_control_status_registers_tb_top;
  import daa_regs_pkg::*;
  logic MCLK;
  logic RST_N;
  avs_req_t req;
  logic [31:0] rdata;
  logic wreq;
  line_status_t status;
  logic [31:0][7:0] ctrl_regs;
  line_ctrl_t line_ctrl;
  logic irq;
  int miscompares;
  int tests_run;
  int k;
  logic [7:0] got;
  logic [7:0] wd;
  // Random targets and the bits that read back as written (unmapped ones included)
  logic [5:0] r_idx [16] = '{6'h02, 6'h05, 6'h06, 6'h07, 6'h08, 6'h0A, 6'h0D, 6'h0E,
    6'h10, 6'h11, 6'h12, 6'h14, 6'h15, 6'h16, 6'h1A, 6'h22};
  logic [7:0] r_msk [16] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'hFF,
    8'hFF, 8'h00, 8'h00, 8'h9F, 8'hB8, 8'hFF, 8'h00, 8'h00};
  // Short gap keeps the run short; revisions are arbitrary values
  daa_control_status_registers #(.LS_GAP(20), .HOST_REV(4'h5), .LINE_REV(4'hA)) dut (
    .MCLK(MCLK), .RST_N(RST_N), .AVS_REQ(req), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wreq), .STATUS(status), .CTRL_REGS(ctrl_regs),
    .LINE_CTRL(line_ctrl), .IRQ(irq));
  daa_host_model host (.MCLK(MCLK), .READDATA(rdata), .WAITREQUEST(wreq), .REQ(req));
  // Clock of 20 ns
  always #10 MCLK = ~MCLK;
  // Readable value after reset with all status inputs low
  function automatic logic [7:0] exp_rst(input logic [5:0] i);
    case (i)
      6'h03: exp_rst = 8'hF0;
      6'h04: exp_rst = 8'hF5;
      6'h05: exp_rst = 8'h0B;
      6'h08: exp_rst = 8'hDA;
      6'h09: exp_rst = 8'hEF;
      6'h0A: exp_rst = 8'h31;
      6'h0B: exp_rst = 8'h2A;
      6'h0C: exp_rst = 8'h06;
      6'h0D: exp_rst = 8'h02;
      6'h0F: exp_rst = 8'h2C;
      6'h16, 6'h18: exp_rst = 8'h01;
      6'h1D: exp_rst = 8'hA0;
      default: exp_rst = 8'h00;
    endcase
  endfunction
  task automatic wrap_up;
    if (miscompares == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Bus access; a hung wait ends the run
  task automatic acc(input logic wr, input logic [5:0] i, input logic [7:0] d);
    host.xfer(wr, i, d, got);
    if (host.timed_out)
    begin
      miscompares++;
      $display("CHECK FAILED %0t bus wait timed out", $time);
      wrap_up();
    end
  endtask
  initial
  begin
    MCLK = 1'b0;
    RST_N = 1'b0;
    status = '0;
    miscompares = 0;
    tests_run = 0;
    wd = 8'($urandom(32'hE372));
    repeat (4) @(posedge MCLK);
    RST_N <= 1'b1;
    for (int i = 1; i < 32; i++)
    begin
      if (i == 17)
        continue;
      acc(1'b0, i[5:0], 8'h00);
      cmp8(got, exp_rst(i[5:0]));
    end
    // Random write then read back, line-side ones back to back
    repeat (40)
    begin
      k = $urandom_range(15);
      wd = 8'($urandom());
      acc(1'b1, r_idx[k], wd);
      acc(1'b0, r_idx[k], 8'h00);
      cmp8(got, wd & r_msk[k]);
    end
    acc(1'b1, 6'h12, 8'hFF);
    cmp8({5'h0, line_ctrl.dc_termination_enable, line_ctrl.ac_termination_enable,
      line_ctrl.low_side_feature_enable}, 8'h07);
    cmp8(ctrl_regs[18], 8'hFF);
    acc(1'b1, 6'h15, 8'h05);
    cmp8({5'h0, line_ctrl.under_voltage_detect_enable, line_ctrl.over_voltage_detect_enable,
      line_ctrl.over_current_detect_enable}, 8'h05);
    acc(1'b1, 6'h0D, 8'h08);
    cmp8({7'h0, line_ctrl.sample_rate_change_request}, 8'h01);
    acc(1'b1, 6'h05, 8'h0A);
    cmp8({7'h0, line_ctrl.ring_status_enable}, 8'h00);
    acc(1'b1, 6'h05, 8'h0B);
    // Read-only values follow the inputs, not the bus
    wd = 8'($urandom());
    @(posedge MCLK);
    status.ring_sample <= wd;
    status.line_voltage <= 8'hFF;
    acc(1'b1, 6'h1A, ~wd);
    acc(1'b0, 6'h1A, 8'h00);
    cmp8(got, wd);
    acc(1'b0, 6'h1B, 8'h00);
    cmp8(got, 8'hFE);
    // Interrupt: raise, read, clear, mask
    acc(1'b1, 6'h21, 8'h01);
    @(posedge MCLK);
    status.ring_detect <= 1'b1;
    repeat (3) @(negedge MCLK);
    cmp8({7'h0, irq}, 8'h01);
    acc(1'b0, 6'h20, 8'h00);
    cmp8(got, 8'h09);
    @(posedge MCLK);
    status.ring_detect <= 1'b0;
    acc(1'b1, 6'h20, 8'h01);
    acc(1'b0, 6'h20, 8'h00);
    cmp8(got, 8'h08);
    cmp8({7'h0, irq}, 8'h00);
    acc(1'b1, 6'h21, 8'h08);
    repeat (2) @(negedge MCLK);
    cmp8({7'h0, irq}, 8'h01);
    acc(1'b1, 6'h21, 8'h00);
    repeat (2) @(negedge MCLK);
    cmp8({7'h0, irq}, 8'h00);
    // Over-current event fires through its write-only enable
    @(posedge MCLK);
    status.line_fault <= 5'h02;
    acc(1'b0, 6'h1E, 8'h00);
    cmp8(got, 8'h10);
    acc(1'b1, 6'h21, 8'h10);
    cmp8({7'h0, irq}, 8'h01);
    wrap_up();
  end
endmodule // daa_control_status_registers_tb_top
bind daa_control_status_registers daa_csr_sva #(.LS_GAP(LS_GAP)) sva (
  .MCLK(MCLK), .RST_N(RST_N), .AVS_REQ(AVS_REQ), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .STATUS(STATUS), .LINE_CTRL(LINE_CTRL), .IRQ(IRQ));
